/* File: bench/qds_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host side of the byte ports; hold sets how slow it is (3 clocks minimum)
module qds_host import qds_pkg::*; (
  input wire logic clk_in,                     // system clock
  output logic ctrl_wr_out,                    // control byte port write
  output logic data_wr_out,                    // data byte port write
  output logic [QDS_DATA_W-1:0] bus_data_out,  // host data byte
  output logic gstrobe_b_out                   // global strobe, active low
);
  // idle levels at time zero
  initial begin
    ctrl_wr_out = 1'b0;
    data_wr_out = 1'b0;
    bus_data_out = 8'h00;
    gstrobe_b_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // byte settles before the strobe rises and stays until after it falls
  task automatic wr(input logic to_ctrl, input logic [7:0] d, input int hold);
    bus_data_out = d; // polarity already in bit 7 of high bytes
    tick(hold);
    if (to_ctrl) ctrl_wr_out = 1'b1;
    else data_wr_out = 1'b1;
    tick(hold);
    ctrl_wr_out = 1'b0;
    data_wr_out = 1'b0;
    tick(1);
    bus_data_out = ~d; // released bus must not keep the old byte
    tick(hold);
  endtask
  task automatic strobe(input int hold);
    gstrobe_b_out = 1'b0;
    tick(hold);
    gstrobe_b_out = 1'b1;
    tick(hold + 1);
  endtask
endmodule // qds_host
`default_nettype wire

/* File: bench/tb_quad_dac_register_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench for the register sequencer, host model on the byte ports
module tb_quad_dac_register_sequencer;
  import qds_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ctrl_wr, data_wr, gstrobe_b;
  logic [7:0] bus_data;
  logic [47:0] code, exp_code;
  logic [3:0] neg_b, pos_b, ptr, exp_neg;
  logic [15:0] rsel, exp_rsel;
  int miscompares = 0;
  int samples_checked = 0;
  always #20 clk_in = ~clk_in;
  qds_top u_qds_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .ctrl_wr_in(ctrl_wr), .data_wr_in(data_wr), .bus_data_in(bus_data),
    .gstrobe_b_in(gstrobe_b), .code_out(code), .ref_neg_b_out(neg_b),
    .ref_pos_b_out(pos_b), .range_sel_out(rsel), .reg_ptr_out(ptr));
  qds_host u_qds_host (.clk_in(clk_in), .ctrl_wr_out(ctrl_wr),
    .data_wr_out(data_wr), .bus_data_out(bus_data), .gstrobe_b_out(gstrobe_b));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ========================================================================
  // scenarios
  task automatic t_reset();
    exp_code = 48'h0;
    exp_neg = 4'hf;
    chk(code, exp_code);
    chk(48'(neg_b), 48'(exp_neg));
    chk(48'(pos_b), 48'h0);
    chk(48'(rsel), 48'h1111);
    chk(48'(ptr), 48'h0);
  endtask
  // enter at a range register, every code once, wrap into the data loop
  task automatic t_ranges();
    u_qds_host.wr(1'b1, 8'h6c, 3);
    chk(48'(ptr), 48'hc);
    for (int p = 12; p < 16; p++) begin
      u_qds_host.wr(1'b0, 8'(p - 12), 3);
      chk(48'(ptr), 48'((p + 1) % 16));
      exp_rsel[4*(15-p) +: 4] = 4'h1 << (p - 12);
    end
    chk(48'(rsel), 48'(exp_rsel));
  endtask
  // immediate mode: an output moves only when its high byte lands
  task automatic t_data();
    for (int c = 0; c < 4; c++) begin
      u_qds_host.wr(1'b0, 8'(8'h5a + c), 3);
      chk(48'(ptr), 48'(2 * c + 1));
      chk(code, exp_code);
      u_qds_host.wr(1'b0, {c[0], 3'h0, 4'(c + 9)}, 3);
      chk(48'(ptr), 48'((c == 3) ? 0 : 2 * c + 2));
      exp_code[12*c +: 12] = {4'(c + 9), 8'(8'h5a + c)};
      exp_neg[c] = ~c[0];
      chk(code, exp_code);
      chk(48'(neg_b), 48'(exp_neg));
      chk(48'(pos_b), 48'(exp_neg ^ 4'hf));
    end
  endtask
  // strobe mode, last channel 0: clear waits for the end of the pulse
  task automatic t_strobe();
    u_qds_host.wr(1'b1, 8'h80, 3);
    u_qds_host.wr(1'b0, 8'hc3, 3);
    fork
      u_qds_host.wr(1'b0, 8'h8e, 5);
      begin
        tick(8);
        chk(48'(ptr), 48'h1);
      end
    join
    chk(48'(ptr), 48'h0);
    chk(code, exp_code);
    u_qds_host.strobe(3);
    exp_code[11:0] = 12'he_c3;
    exp_neg[0] = 1'b0;
    chk(code, exp_code);
    chk(48'(neg_b), 48'(exp_neg));
  endtask
  // reset in mid-run must clear what the earlier scenarios wrote
  task automatic t_mid_reset();
    rst_b_in = 1'b0;
    tick(2);
    rst_b_in = 1'b1;
    tick(2);
    t_reset();
  endtask
  // ========================================================================
  // main sequence and hang guard
  initial begin
    tick(16);
    rst_b_in = 1'b1;
    tick(2);
    t_reset();
    t_ranges();
    t_data();
    t_strobe();
    t_mid_reset();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
endmodule // tb_quad_dac_register_sequencer
`default_nettype wire

/* File: verilog/qds_chan.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// one output channel: first-level latches, output latch, selects
module qds_chan import qds_pkg::*; #(
  parameter int CH = 0
) (
  input wire logic clk_in,                 // system clock
  input wire logic rst_b_in,               // async reset, active low
  qds_wr_if.chan wr,                       // write path
  output logic [QDS_MAG_W-1:0] code_out,   // magnitude to converter
  output logic ref_neg_b_out,              // negative reference select
  output logic ref_pos_b_out,              // positive reference select
  output logic [QDS_SEL_N-1:0] range_sel_out // divide by 1, 2, 5, 10
);
  localparam int LO_IDX = 2 * CH;
  localparam int HI_IDX = 2 * CH + 1;
  localparam int RG_IDX = int'(QDS_RANGE_CH0) - CH;

  logic [QDS_DATA_W-1:0] lo_r, lo_nxt, hi_r, hi_nxt;
  logic [QDS_RNG_W-1:0] rng_r, rng_nxt;
  logic [QDS_MAG_W-1:0] code_r, code_nxt;
  logic pol_r, pol_nxt;

  // ========================================================================
  // latch next values; the output stage lags the first level so that all
  // channels can be released together by the strobe
  always_comb begin
    lo_nxt = lo_r;
    hi_nxt = hi_r;
    rng_nxt = rng_r;
    code_nxt = code_r;
    pol_nxt = pol_r;
    if (wr.wr_en[LO_IDX]) lo_nxt = wr.wr_data;
    if (wr.wr_en[HI_IDX]) hi_nxt = wr.wr_data;
    if (wr.wr_en[RG_IDX]) rng_nxt = wr.wr_data[QDS_RNG_W-1:0];
    if (wr.wr_en[HI_IDX] && !wr.gstb_en) begin
      code_nxt = {wr.wr_data[QDS_HI_MAG_MSB:0], lo_r};
      pol_nxt = wr.wr_data[QDS_HI_POL_BIT];
    end else if (wr.gstb_en && wr.gstb_pulse) begin
      code_nxt = {hi_r[QDS_HI_MAG_MSB:0], lo_r};
      pol_nxt = hi_r[QDS_HI_POL_BIT];
    end
  end

  // power-up clears every latch, giving zero volts on the output
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lo_r <= QDS_BYTE_RST;
      hi_r <= QDS_BYTE_RST;
      rng_r <= QDS_RNG_RST;
      code_r <= QDS_MAG_RST;
      pol_r <= QDS_BYTE_RST[QDS_HI_POL_BIT];
    end else begin
      lo_r <= lo_nxt;
      hi_r <= hi_nxt;
      rng_r <= rng_nxt;
      code_r <= code_nxt;
      pol_r <= pol_nxt;
    end
  end

  // exactly one reference select is low at any time
  assign code_out = code_r;
  assign ref_neg_b_out = ~pol_r;
  assign ref_pos_b_out = pol_r;
  assign range_sel_out = qds_range_dec(rng_r);

  // ========================================================================
  // checks
  a_pol_select: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    (ref_neg_b_out == !pol_r) && (ref_pos_b_out != ref_neg_b_out))
    else $error("reference selects do not follow polarity");
  a_range_onehot: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $onehot(range_sel_out) && range_sel_out == (4'h1 << rng_r))
    else $error("range selects not one-hot of stored range");
  a_imm_update: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    wr.wr_en[HI_IDX] && !wr.gstb_en |=>
    code_out == {$past(wr.wr_data[QDS_HI_MAG_MSB:0]), $past(lo_r)}
    && pol_r == $past(wr.wr_data[QDS_HI_POL_BIT]))
    else $error("immediate update did not load the output");
  a_strobe_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    wr.gstb_en && !wr.gstb_pulse |=> $stable(code_out))
    else $error("output changed without global strobe");
  // a strobe copies the stored bytes, polarity included
  a_strobe_copy: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    wr.gstb_en && wr.gstb_pulse |=>
    code_out == $past({hi_r[QDS_HI_MAG_MSB:0], lo_r})
    && ref_neg_b_out == !$past(hi_r[QDS_HI_POL_BIT]))
    else $error("global strobe did not copy the stored bytes");
endmodule // qds_chan
`default_nettype wire

/* File: verilog/qds_pkg.sv */
`default_nettype none
// ==========================================================================
// shared constants for the four-channel output register sequencer
package qds_pkg;
  localparam int QDS_CH_N = 4;      // output channels
  localparam int QDS_PTR_W = 4;     // register pointer width
  localparam int QDS_REG_N = 16;    // pointer decode space
  localparam int QDS_DATA_W = 8;    // byte port width
  localparam int QDS_MAG_W = 12;    // converter magnitude width
  localparam int QDS_RNG_W = 2;     // stored range code width
  localparam int QDS_SEL_N = 4;     // range selects per channel
  // control byte layout
  localparam int QDS_CTRL_PTR_LSB = 0;  // pointer load field, bits 3..0
  localparam int QDS_CTRL_FLD_LSB = 4;  // upper field, bits 7..4
  localparam int QDS_FLD_LAST_LSB = 1;  // last channel, byte bits 6..5
  localparam int QDS_FLD_GSTB_BIT = 3;  // strobe enable, byte bit 7
  // high data byte layout
  localparam int QDS_HI_POL_BIT = 7;    // 1 = negative output
  localparam int QDS_HI_MAG_MSB = 3;    // magnitude bits 11..8 in 3..0
  // register numbers: data 0..7, range for channel c at 15 - c
  localparam logic [QDS_PTR_W-1:0] QDS_RANGE_CH0 = 4'hf;
  // reset values
  localparam logic [QDS_PTR_W-1:0] QDS_PTR_RST = 4'h0;
  localparam logic [3:0] QDS_FLD_RST = 4'h0;
  localparam logic [QDS_DATA_W-1:0] QDS_BYTE_RST = 8'h00;
  localparam logic [QDS_MAG_W-1:0] QDS_MAG_RST = 12'h000;
  localparam logic [QDS_RNG_W-1:0] QDS_RNG_RST = 2'h0;

  // range code 0..3 -> divide by 1, 2, 5, 10 (one-hot, bit 0 = by 1)
  function automatic logic [QDS_SEL_N-1:0] qds_range_dec(
    input logic [QDS_RNG_W-1:0] code);
    qds_range_dec = 4'h1 << code;
  endfunction
endpackage
`default_nettype wire

/* File: verilog/qds_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Function
// - power-up clears all data and range latches
// - four-bit pointer names next data target
// - pointer decoded to one-hot latch write enables
// - control write loads pointer and upper field
// - data write compares pointer with last channel
// - match clears pointer to channel 0 low
// - clear applied at end of write pulse
// - polarity drives one of two reference selects
// - range code gives one of four selects
// - twelve-bit magnitude presented as unsigned fraction
// - no match advances pointer to next register
// - registers 0-7 data, 12-15 ranges reversed
// - high byte bit 7 selects negative output
module qds_top import qds_pkg::*; (
  input wire logic clk_in,                      // 25 mhz system clock
  input wire logic rst_b_in,                    // async reset, active low
  input wire logic ctrl_wr_in,                  // control byte port write
  input wire logic data_wr_in,                  // data byte port write
  input wire logic [QDS_DATA_W-1:0] bus_data_in, // host data byte
  input wire logic gstrobe_b_in,                // global strobe, low
  output logic [QDS_CH_N*QDS_MAG_W-1:0] code_out, // magnitudes, ch0 low
  output logic [QDS_CH_N-1:0] ref_neg_b_out,    // negative ref select
  output logic [QDS_CH_N-1:0] ref_pos_b_out,    // positive ref select
  output logic [QDS_CH_N*QDS_SEL_N-1:0] range_sel_out, // range selects
  output logic [QDS_PTR_W-1:0] reg_ptr_out      // current pointer
);
  localparam int SYN_W = QDS_DATA_W + 3;

  // pointer to one-hot latch enable
  function automatic logic [QDS_REG_N-1:0] qds_ptr_dec(
    input logic [QDS_PTR_W-1:0] p);
    qds_ptr_dec = 16'h0001 << p;
  endfunction

  // ========================================================================
  // pin synchronisers: the host strobes are asynchronous to clk_in
  // the byte rides the same chain, so it stays aligned with its strobe
  logic [SYN_W-1:0] syn1_r, syn1_nxt, syn2_r, syn2_nxt;
  logic [2:0] dly_r, dly_nxt;
  localparam logic [SYN_W-1:0] SYN_RST = {3'b001, QDS_BYTE_RST};

  always_comb begin
    syn1_nxt = {ctrl_wr_in, data_wr_in, gstrobe_b_in, bus_data_in};
    syn2_nxt = syn1_r;
    dly_nxt = syn2_r[SYN_W-1 -: 3];
  end

  // third stage keeps the previous strobe levels for the edge detectors
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      syn1_r <= SYN_RST;
      syn2_r <= SYN_RST;
      dly_r <= SYN_RST[SYN_W-1 -: 3];
    end else begin
      syn1_r <= syn1_nxt;
      syn2_r <= syn2_nxt;
      dly_r <= dly_nxt;
    end
  end

  // edge detection on the second stage only
  logic ctrl_s, data_s, gstb_b_s;
  logic [QDS_DATA_W-1:0] byte_s;
  logic ctrl_rise, data_rise, data_fall, gstb_fall;
  assign {ctrl_s, data_s, gstb_b_s, byte_s} = syn2_r;
  assign ctrl_rise = ctrl_s && !dly_r[2];
  assign data_rise = data_s && !dly_r[1];
  assign data_fall = !data_s && dly_r[1];
  assign gstb_fall = !gstb_b_s && dly_r[0];

  // ========================================================================
  // pointer and control field
  logic [QDS_PTR_W-1:0] ptr_r, ptr_nxt;
  logic [3:0] fld_r, fld_nxt;
  logic [1:0] last_ch;
  logic last_hit;

  // the last register of a run is the high byte of the last channel;
  // range registers never match, so a run from them always falls into 0
  assign last_ch = fld_r[QDS_FLD_LAST_LSB +: 2];
  assign last_hit = (ptr_r == {1'b0, last_ch, 1'b1});

  // a control load wins over a data write ending in the same cycle
  always_comb begin
    ptr_nxt = ptr_r;
    fld_nxt = fld_r;
    if (ctrl_rise) begin
      ptr_nxt = byte_s[QDS_CTRL_PTR_LSB +: QDS_PTR_W];
      fld_nxt = byte_s[QDS_CTRL_FLD_LSB +: 4];
    end else if (data_fall) begin
      if (last_hit) ptr_nxt = QDS_PTR_RST;
      else ptr_nxt = ptr_r + 4'h1;
    end
  end

  // pointer and control field registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_r <= QDS_PTR_RST;
      fld_r <= QDS_FLD_RST;
    end else begin
      ptr_r <= ptr_nxt;
      fld_r <= fld_nxt;
    end
  end

  // ========================================================================
  // write path: byte stored at the start of the pulse, pointer moves later
  qds_wr_if wr ();
  assign wr.wr_en = data_rise ? qds_ptr_dec(ptr_r) : '0;
  assign wr.wr_data = byte_s;
  assign wr.gstb_en = fld_r[QDS_FLD_GSTB_BIT];
  assign wr.gstb_pulse = gstb_fall;
  assign reg_ptr_out = ptr_r;

  // registers 8..11 decode to enables that no channel uses
  genvar g;
  generate
    for (g = 0; g < QDS_CH_N; g++) begin : g_ch
      qds_chan #(.CH(g)) u_chan (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .wr(wr.chan),
        .code_out(code_out[g*QDS_MAG_W +: QDS_MAG_W]),
        .ref_neg_b_out(ref_neg_b_out[g]),
        .ref_pos_b_out(ref_pos_b_out[g]),
        .range_sel_out(range_sel_out[g*QDS_SEL_N +: QDS_SEL_N])
      );
    end
  endgenerate

  // ========================================================================
  // checks
  // a control write loads the pointer from the low nibble
  a_ctrl_load_ptr: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_rise |=> ptr_r == $past(byte_s[QDS_CTRL_PTR_LSB +: QDS_PTR_W]))
    else $error("control write did not load pointer");

  // and keeps the upper nibble as the control field
  a_ctrl_field: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    ctrl_rise |=> fld_r == $past(byte_s[QDS_CTRL_FLD_LSB +: 4]))
    else $error("control write did not store upper field");

  // the field only moves on a control write
  a_fld_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !ctrl_rise |=> $stable(fld_r))
    else $error("control field changed without a control write");

  // pointer only moves on a control write or the end of a data write
  a_ptr_idle_hold: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    !ctrl_rise && !data_fall |=> $stable(ptr_r))
    else $error("pointer moved without a port write");

  // exactly the pointed latch is enabled while a byte is stored
  a_wren_onehot: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    data_rise ? ($onehot(wr.wr_en) && wr.wr_en[ptr_r]) : wr.wr_en == '0)
    else $error("latch enable not one-hot of pointer");

  // the enable is a single pulse; a long write must not store twice
  a_wren_pulse: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    data_rise |=> wr.wr_en == '0)
    else $error("latch enable lasted more than one cycle");

  // only a high-byte register can match, so a run never stops
  // half way through a channel
  a_wrap_clear: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    data_fall && !ctrl_rise && ptr_r == {1'b0, last_ch, 1'b1}
    |=> ptr_r == QDS_PTR_RST)
    else $error("pointer not cleared after last register");

  // otherwise the pointer steps to the next register
  a_ptr_advance: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    data_fall && !ctrl_rise && !last_hit
    |=> ptr_r == 4'($past(ptr_r) + 4'h1))
    else $error("pointer did not advance");

  // any move not caused by a control load is a step or a clear
  a_ptr_no_skip: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    $changed(ptr_r) && !$past(ctrl_rise) |->
    ptr_r == QDS_PTR_RST || ptr_r == 4'($past(ptr_r) + 4'h1))
    else $error("pointer jumped without a control write");

  // the last range register falls into the channel 0 low byte
  a_range_wrap: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    data_fall && !ctrl_rise && ptr_r == QDS_RANGE_CH0
    |=> ptr_r == QDS_PTR_RST)
    else $error("pointer did not leave the range registers at 0");

  // the byte is stored while the pointer still names it; the move
  // waits for the end of the write pulse
  a_store_before: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    data_rise && !ctrl_rise |=> $stable(ptr_r))
    else $error("pointer moved while byte was being stored");

  // a held strobe must not copy the channels more than once
  a_gstb_single: assert property (
    @(posedge clk_in) disable iff (!rst_b_in)
    gstb_fall |=> !gstb_fall)
    else $error("strobe edge lasted more than one cycle");

  // everything is clear as soon as reset lets go
  a_reset_clear: assert property (
    @(posedge clk_in)
    $rose(rst_b_in) |-> code_out == '0 && ptr_r == QDS_PTR_RST
    && ref_pos_b_out == '0)
    else $error("latches not clear after reset");
endmodule // qds_top
`default_nettype wire

/* File: verilog/qds_wr_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// write path from the sequencer to the channel latches
interface qds_wr_if;
  import qds_pkg::*;
  logic [QDS_REG_N-1:0] wr_en;     // one-hot latch enables, one cycle
  logic [QDS_DATA_W-1:0] wr_data;  // byte being stored
  logic gstb_en;                   // magnitudes and reference selects wait for global strobe
  logic gstb_pulse;                // one cycle at strobe assertion
  modport src (output wr_en, wr_data, gstb_en, gstb_pulse);
  modport chan (input wr_en, wr_data, gstb_en, gstb_pulse);
endinterface
`default_nettype wire
